//--- hw/cut_pkg.sv
package cut_pkg;

  ////////////////////////////////////////////////////////////
  // Clock and reference timing
  localparam int unsigned CLK_FREQ_KHZ = 100000;
  localparam int unsigned REF_FREQ_KHZ = 6780;
  localparam logic [16:0] REF_ACC_STEP = 17'(REF_FREQ_KHZ);
  localparam logic [16:0] REF_ACC_WRAP = 17'(CLK_FREQ_KHZ);

  ////////////////////////////////////////////////////////////
  // Register offsets
  localparam logic [15:0] OFS_DIV_LOW = 16'h631b;
  localparam logic [15:0] OFS_RELOAD_UP = 16'h631c;
  localparam logic [15:0] OFS_RELOAD_LO = 16'h631d;
  localparam logic [15:0] OFS_COUNT_UP = 16'h631e;
  localparam logic [15:0] OFS_COUNT_LO = 16'h631f;
  localparam logic [15:0] OFS_MODE = 16'h6310;
  localparam logic [15:0] OFS_CTRL = 16'h6311;
  localparam logic [15:0] OFS_IRQ_STS = 16'h6312;
  localparam logic [15:0] OFS_IRQ_MASK = 16'h6313;

  ////////////////////////////////////////////////////////////
  // Field positions
  localparam int unsigned CTRL_START_BIT = 0;
  localparam int unsigned CTRL_STOP_BIT = 1;
  localparam int unsigned CTRL_RUN_BIT = 0;
  localparam int unsigned IRQ_EXPIRED_BIT = 0;
  localparam int unsigned IRQ_RELOADED_BIT = 1;
  localparam int unsigned IRQ_W = 2;

  ////////////////////////////////////////////////////////////
  // Gating codes
  localparam logic [1:0] GATE_NONE = 2'h0;
  localparam logic [1:0] GATE_SIGNAL = 2'h1;
  localparam logic [1:0] GATE_AUX = 2'h2;

  ////////////////////////////////////////////////////////////
  // Reset values
  localparam logic [7:0] RST_DIV_LOW = 8'h00;
  localparam logic [15:0] RST_RELOAD = 16'h0000;
  localparam logic [15:0] RST_COUNT = 16'h0000;
  localparam logic [6:0] RST_MODE = 7'h00;
  localparam logic [1:0] RST_IRQ = 2'h0;
  localparam logic [11:0] RST_DIV_CNT = 12'h000;

  typedef struct packed {
    logic [1:0] gating_select;
    logic auto_reload_enable;
    logic [3:0] divider_high_nibble;
  } cut_mode_t;

  typedef enum logic {
    ST_IDLE,
    ST_RUN
  } cut_state_t;

endpackage

//--- hw/cut_divider.sv
`timescale 1ns/1ps
`default_nettype none

module cut_divider (
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic clear_i,
  input wire logic ref_tick_i,
  input wire logic [11:0] divisor_i,
  output logic tick_o
);

  logic [11:0] cnt_q;
  logic [11:0] last;
  logic wrap;

  // Divisor zero is taken as one, so the timer never hangs
  always_comb begin
    last = (divisor_i == 12'h000) ? 12'h000 : divisor_i - 12'h001;
    wrap = (cnt_q >= last);
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_q <= cut_pkg::RST_DIV_CNT;
    end else if (clear_i) begin
      cnt_q <= cut_pkg::RST_DIV_CNT;
    end else if (ref_tick_i) begin
      cnt_q <= wrap ? cut_pkg::RST_DIV_CNT : cnt_q + 12'h001;
    end
  end

  assign tick_o = ref_tick_i && wrap && !clear_i; // [RL1]

endmodule // cut_divider

`default_nettype wire

//--- hw/cut_timer.sv
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// RL1 - Tick rate is reference over prescaler
// RL2 - Prescaler is mode nibble plus low byte
// RL3 - Reload value held in two bytes
// RL4 - Start event loads counter from reload
// RL5 - Reload writes wait for next start; with auto reload the next wrap also loads them
// RL6 - Live count readable as two bytes
// RL7 - Gating: none, signal pin, aux pin
// RL8 - No auto reload: stop at zero, flag
// RL9 - Auto reload: reload at zero, continue
module cut_timer (
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic [15:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [7:0] reg_rdata_o,
  input wire logic signal_input_pin_i,
  input wire logic auxiliary_gate_pin_i,
  output logic running_o,
  output logic timer_expired_flag_o,
  output logic irq_o
);

  ////////////////////////////////////////////////////////////
  // Declarations

  logic [7:0] divider_low_byte_q;
  cut_pkg::cut_mode_t mode_q;
  logic [7:0] reload_upper_byte_q;
  logic [7:0] reload_lower_byte_q;
  logic [15:0] count_q;
  logic [15:0] count_d;
  cut_pkg::cut_state_t state_q;
  cut_pkg::cut_state_t state_d;
  logic [16:0] ref_acc_q;
  logic [16:0] ref_acc_sum;
  logic ref_tick;
  logic [11:0] divisor;
  logic [15:0] reload_value;
  logic div_tick;
  logic gate_open;
  logic count_tick;
  logic start_evt;
  logic stop_evt;
  logic expire_evt;
  logic reload_evt;
  logic [cut_pkg::IRQ_W-1:0] irq_sts_q;
  logic [cut_pkg::IRQ_W-1:0] irq_mask_q;
  logic [cut_pkg::IRQ_W-1:0] irq_set;
  logic [cut_pkg::IRQ_W-1:0] irq_clr;
  logic [7:0] rdata_q;
  logic [7:0] rdata_d;
  logic count_at_zero;
  logic count_at_one;
  logic count_step;
  logic div_clear;
  logic sel_div_low;
  logic sel_mode;
  logic sel_reload_up;
  logic sel_reload_lo;
  logic sel_ctrl;
  logic sel_irq_sts;
  logic sel_irq_mask;
  logic wr_div_low;
  logic wr_mode;
  logic wr_reload_up;
  logic wr_reload_lo;
  logic wr_ctrl;
  logic wr_irq_sts;
  logic wr_irq_mask;

  ////////////////////////////////////////////////////////////
  // Address decode

  // Exact match only, so aliased addresses stay unmapped
  always_comb begin
    sel_div_low = (reg_addr_i == cut_pkg::OFS_DIV_LOW);
    sel_mode = (reg_addr_i == cut_pkg::OFS_MODE);
    sel_reload_up = (reg_addr_i == cut_pkg::OFS_RELOAD_UP);
    sel_reload_lo = (reg_addr_i == cut_pkg::OFS_RELOAD_LO);
    sel_ctrl = (reg_addr_i == cut_pkg::OFS_CTRL);
    sel_irq_sts = (reg_addr_i == cut_pkg::OFS_IRQ_STS);
    sel_irq_mask = (reg_addr_i == cut_pkg::OFS_IRQ_MASK);
  end

  // Count bytes get no write enable: writes there are dropped
  always_comb begin
    wr_div_low = reg_wr_i && sel_div_low;
    wr_mode = reg_wr_i && sel_mode;
    wr_reload_up = reg_wr_i && sel_reload_up;
    wr_reload_lo = reg_wr_i && sel_reload_lo;
    wr_ctrl = reg_wr_i && sel_ctrl;
    wr_irq_sts = reg_wr_i && sel_irq_sts;
    wr_irq_mask = reg_wr_i && sel_irq_mask;
  end

  ////////////////////////////////////////////////////////////
  // Register writes

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      divider_low_byte_q <= cut_pkg::RST_DIV_LOW;
    end else if (wr_div_low) begin
      divider_low_byte_q <= reg_wdata_i;
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      mode_q <= cut_pkg::RST_MODE;
    end else if (wr_mode) begin
      mode_q <= reg_wdata_i[6:0];
    end
  end

  // Reload bytes only feed the counter on a start or a wrap
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      reload_upper_byte_q <= cut_pkg::RST_RELOAD[15:8];
    end else if (wr_reload_up) begin
      reload_upper_byte_q <= reg_wdata_i; // [RL3] [RL5]
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      reload_lower_byte_q <= cut_pkg::RST_RELOAD[7:0];
    end else if (wr_reload_lo) begin
      reload_lower_byte_q <= reg_wdata_i; // [RL3] [RL5]
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      irq_mask_q <= cut_pkg::RST_IRQ;
    end else if (wr_irq_mask) begin
      irq_mask_q <= reg_wdata_i[cut_pkg::IRQ_W-1:0];
    end
  end

  // Stop wins when both control bits are written at once
  always_comb begin
    start_evt = 1'b0;
    stop_evt = 1'b0;
    if (wr_ctrl) begin
      stop_evt = reg_wdata_i[cut_pkg::CTRL_STOP_BIT];
      start_evt = reg_wdata_i[cut_pkg::CTRL_START_BIT] && !stop_evt;
    end
  end

  ////////////////////////////////////////////////////////////
  // Reference tick and prescaler

  // Fractional accumulator keeps the long-run rate exact
  always_comb begin
    ref_acc_sum = ref_acc_q + cut_pkg::REF_ACC_STEP;
    ref_tick = (ref_acc_sum >= cut_pkg::REF_ACC_WRAP);
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ref_acc_q <= '0;
    end else if (ref_tick) begin
      ref_acc_q <= ref_acc_sum - cut_pkg::REF_ACC_WRAP; // [RL1]
    end else begin
      ref_acc_q <= ref_acc_sum;
    end
  end

  assign divisor = {mode_q.divider_high_nibble, divider_low_byte_q}; // [RL2]
  assign reload_value = {reload_upper_byte_q, reload_lower_byte_q};

  // Prescale phase restarts with each start, so the first tick is a full period
  assign div_clear = start_evt || (state_q != cut_pkg::ST_RUN);

  cut_divider u_divider (
    .clk_sys_i(clk_sys_i),
    .rst_n_i(rst_n_i),
    .clear_i(div_clear),
    .ref_tick_i(ref_tick),
    .divisor_i(divisor),
    .tick_o(div_tick)
  );

  ////////////////////////////////////////////////////////////
  // Gating

  // Reserved code counts like ungated mode
  always_comb begin
    case (mode_q.gating_select) // [RL7]
      cut_pkg::GATE_NONE: gate_open = 1'b1;
      cut_pkg::GATE_SIGNAL: gate_open = signal_input_pin_i;
      cut_pkg::GATE_AUX: gate_open = auxiliary_gate_pin_i;
      default: gate_open = 1'b1;
    endcase
  end

  assign count_tick = div_tick && gate_open;

  ////////////////////////////////////////////////////////////
  // Counter and run state

  assign count_at_zero = (count_q == 16'h0000);
  assign count_at_one = (count_q == 16'h0001);
  assign count_step = (state_q == cut_pkg::ST_RUN) && !stop_evt && !start_evt && count_tick;

  // In auto reload mode the flag marks the wrap itself, once a period;
  // a zero reload value expires on every tick
  always_comb begin
    expire_evt = 1'b0;
    reload_evt = 1'b0;
    if (count_step) begin
      if (count_at_zero) begin
        expire_evt = 1'b1; // [RL9]
        reload_evt = mode_q.auto_reload_enable; // [RL9]
      end else if (count_at_one) begin
        expire_evt = !mode_q.auto_reload_enable; // [RL8]
      end
    end
  end

  // Stop freezes the count so firmware can read where it halted
  always_comb begin
    count_d = count_q;
    if (start_evt) begin
      count_d = reload_value; // [RL4]
    end else if (count_step) begin
      if (reload_evt) begin
        count_d = reload_value; // [RL9]
      end else if (!count_at_zero) begin
        count_d = count_q - 16'h0001;
      end
    end
  end

  always_comb begin
    state_d = state_q;
    case (state_q)
      cut_pkg::ST_IDLE: begin
        if (start_evt) begin
          state_d = cut_pkg::ST_RUN; // [RL4]
        end
      end
      cut_pkg::ST_RUN: begin
        if (stop_evt) begin
          state_d = cut_pkg::ST_IDLE;
        end else if (expire_evt && !mode_q.auto_reload_enable) begin
          state_d = cut_pkg::ST_IDLE; // [RL8]
        end
      end
      default: begin
        state_d = cut_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      count_q <= cut_pkg::RST_COUNT;
    end else begin
      count_q <= count_d;
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_q <= cut_pkg::ST_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  assign running_o = (state_q == cut_pkg::ST_RUN);

  ////////////////////////////////////////////////////////////
  // Interrupt status

  always_comb begin
    irq_set = '0;
    irq_set[cut_pkg::IRQ_EXPIRED_BIT] = expire_evt; // [RL8]
    irq_set[cut_pkg::IRQ_RELOADED_BIT] = reload_evt; // [RL9]
  end

  // Write one to clear; zero bits leave the status alone
  always_comb begin
    irq_clr = '0;
    if (wr_irq_sts) begin
      irq_clr = reg_wdata_i[cut_pkg::IRQ_W-1:0];
    end
  end

  // A new event in the clearing cycle survives the clear
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      irq_sts_q <= cut_pkg::RST_IRQ;
    end else begin
      irq_sts_q <= (irq_sts_q & ~irq_clr) | irq_set;
    end
  end

  assign timer_expired_flag_o = irq_sts_q[cut_pkg::IRQ_EXPIRED_BIT];
  assign irq_o = |(irq_sts_q & irq_mask_q);

  ////////////////////////////////////////////////////////////
  // Read path

  always_comb begin
    rdata_d = 8'h00;
    if (reg_rd_i) begin
      case (reg_addr_i)
        cut_pkg::OFS_DIV_LOW: rdata_d = divider_low_byte_q;
        cut_pkg::OFS_RELOAD_UP: rdata_d = reload_upper_byte_q;
        cut_pkg::OFS_RELOAD_LO: rdata_d = reload_lower_byte_q;
        cut_pkg::OFS_COUNT_UP: rdata_d = count_q[15:8]; // [RL6]
        cut_pkg::OFS_COUNT_LO: rdata_d = count_q[7:0]; // [RL6]
        cut_pkg::OFS_MODE: rdata_d = {1'b0, mode_q};
        cut_pkg::OFS_CTRL: rdata_d[cut_pkg::CTRL_RUN_BIT] = running_o;
        cut_pkg::OFS_IRQ_STS: rdata_d[cut_pkg::IRQ_W-1:0] = irq_sts_q;
        cut_pkg::OFS_IRQ_MASK: rdata_d[cut_pkg::IRQ_W-1:0] = irq_mask_q;
        default: rdata_d = 8'h00;
      endcase
    end
  end

  // Data stands only in the cycle after the read strobe
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rdata_q <= 8'h00;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  assign reg_rdata_o = rdata_q;

endmodule // cut_timer

`default_nettype wire

//--- test/cut_timer_properties.sv
`timescale 1ns/1ps
`default_nettype none
module cut_timer_chk (
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic [15:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [7:0] reg_rdata_o,
  input wire logic signal_input_pin_i,
  input wire logic auxiliary_gate_pin_i,
  input wire logic running_o,
  input wire logic timer_expired_flag_o,
  input wire logic irq_o
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n_i);
  logic ctl_w, go, halt, clr;
  assign ctl_w = reg_wr_i && reg_addr_i == cut_pkg::OFS_CTRL;
  assign go = ctl_w && reg_wdata_i[0] && !reg_wdata_i[1];
  assign halt = ctl_w && reg_wdata_i[1];
  assign clr = reg_wr_i && reg_addr_i == cut_pkg::OFS_IRQ_STS && reg_wdata_i[0];
  sequence s_div_wr;
    reg_wr_i && reg_addr_i == cut_pkg::OFS_DIV_LOW;
  endsequence
  sequence s_div_rd;
    reg_rd_i && reg_addr_i == cut_pkg::OFS_DIV_LOW;
  endsequence
  ////////////////////////////////////////
  chk_start_runs: assert property (go |=> running_o)
    else $error("start ignored");
  chk_run_cause: assert property ($rose(running_o) |-> $past(go))
    else $error("run without start");
  chk_stop_halts: assert property (halt |=> !running_o)
    else $error("stop ignored");
  // Flag may trail the stop by one edge
  chk_stop_expiry: assert property ($fell(running_o) && !$past(halt) |-> ##[0:1] timer_expired_flag_o)
    else $error("stopped without expiry");
  chk_flag_cause: assert property ($rose(timer_expired_flag_o) |-> $past(running_o) || $past(running_o, 2))
    else $error("flag while idle");
  chk_flag_sticky: assert property ($fell(timer_expired_flag_o) |-> $past(clr))
    else $error("flag lost");
  chk_read_idle: assert property (!$past(reg_rd_i) |-> reg_rdata_o == 8'h00)
    else $error("data without read");
  chk_div_readback: assert property (s_div_wr ##1 !reg_wr_i ##1 s_div_rd |=> reg_rdata_o == $past(reg_wdata_i, 3))
    else $error("divider byte lost");
  chk_unmapped_zero: assert property (reg_rd_i && reg_addr_i == 16'h6320 |=> reg_rdata_o == 8'h00)
    else $error("unmapped read");
endmodule // cut_timer_chk
bind cut_timer cut_timer_chk chk (.clk_sys_i, .rst_n_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i,
  .reg_rdata_o, .signal_input_pin_i, .auxiliary_gate_pin_i, .running_o, .timer_expired_flag_o, .irq_o);
`default_nettype wire

//--- test/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic clk_sys_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic [15:0] reg_addr_i = 16'h0000;
  logic [7:0] reg_wdata_i = 8'h00;
  logic reg_wr_i = 1'b0;
  logic reg_rd_i = 1'b0;
  logic signal_input_pin_i = 1'b0;
  logic auxiliary_gate_pin_i = 1'b0;
  logic [7:0] reg_rdata_o;
  logic running_o, timer_expired_flag_o, irq_o;
  int n_errors = 0;
  int n_checks = 0;
  int el;
  int dv[2] = '{1, 259};
  logic [15:0] r;
  cut_timer dut (.clk_sys_i, .rst_n_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i,
    .reg_rdata_o, .signal_input_pin_i, .auxiliary_gate_pin_i, .running_o, .timer_expired_flag_o, .irq_o);
  always #5 clk_sys_i = ~clk_sys_i;
  ////////////////////////////////////////
  function automatic int tck(input int d);
    return d * cut_pkg::CLK_FREQ_KHZ / cut_pkg::REF_FREQ_KHZ;
  endfunction
  task automatic tally_and_finish();
    if (n_errors == 0 && n_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD %0t seen %h want %h", $time, seen, exp);
    end
  endtask
  // Strobe drops for one cycle between writes, so no double drive
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk_sys_i);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'b1;
    @(posedge clk_sys_i);
    reg_wr_i <= 1'b0;
    #1;
  endtask
  task automatic rdc(input logic [15:0] a, input logic [7:0] e);
    @(posedge clk_sys_i);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge clk_sys_i);
    reg_rd_i <= 1'b0;
    #1;
    check(reg_rdata_o, e);
  endtask
  task automatic setup(input logic [7:0] m, input logic [7:0] d, input logic [15:0] rl);
    wr(16'h6310, m);
    wr(16'h631b, d);
    wr(16'h631c, rl[15:8]);
    wr(16'h631d, rl[7:0]);
    wr(16'h6311, 8'h01);
  endtask
  task automatic wait_flag(input int lim, input logic want);
    el = 0;
    while (timer_expired_flag_o !== 1'b1 && el < lim) begin
      @(posedge clk_sys_i);
      #1;
      el++;
    end
    check(timer_expired_flag_o, want);
    if (want && timer_expired_flag_o !== 1'b1) tally_and_finish();
  endtask
  ////////////////////////////////////////
  initial begin
    void'($urandom(32'h7628_2aea));
    repeat (16) @(posedge clk_sys_i);
    rst_n_i <= 1'b1;
    for (int a = 0; a < 3; a++) begin
      rdc(16'h631b + 16'(a), 8'h00);
    end
    rdc(16'h6320, 8'h00);
    check({running_o, irq_o}, 2'b00);
    repeat (4) begin
      for (int a = 0; a < 3; a++) begin
        r = 16'($urandom);
        wr(16'h631b + 16'(a), r[7:0]);
        rdc(16'h631b + 16'(a), r[7:0]);
      end
      wr(16'h631e, r[15:8]);
      rdc(16'h631e, 8'h00);
      wr(16'h6310, r[15:8]);
      rdc(16'h6310, {1'b0, r[14:8]});
    end
    // Longest divisor keeps the count still while it is read
    r = 16'($urandom) | 16'h0100;
    setup(8'h0f, 8'hff, r);
    rdc(16'h631e, r[15:8]);
    rdc(16'h631f, r[7:0]);
    wr(16'h631c, ~r[15:8]);
    wr(16'h631d, ~r[7:0]);
    rdc(16'h631e, r[15:8]);
    rdc(16'h631f, r[7:0]);
    wr(16'h6311, 8'h02);
    check(running_o, 1'b0);
    foreach (dv[i]) begin
      wr(16'h6313, 8'h01);
      setup({4'h0, 4'(dv[i] >> 8)}, 8'(dv[i]), 16'h0002);
      wait_flag(9000, 1'b1);
      check(el > tck(dv[i]) * 2 - 24 && el < tck(dv[i]) * 2 + 24, 1'b1);
      check({running_o, irq_o}, 2'b01);
      rdc(16'h631f, 8'h00);
      wr(16'h6313, 8'h00);
      check(irq_o, 1'b0);
      wr(16'h6312, 8'h03);
      check(timer_expired_flag_o, 1'b0);
    end
    setup(8'h10, 8'h01, 16'h0003);
    wait_flag(80, 1'b1);
    check(running_o, 1'b1);
    wr(16'h6312, 8'h03);
    wait_flag(100, 1'b1);
    check(el > tck(1) * 4 - 24, 1'b1);
    rdc(16'h6312, 8'h03);
    wr(16'h6311, 8'h02);
    wr(16'h6312, 8'h03);
    for (int g = 0; g < 4; g++) begin
      setup(8'(g << 5), 8'h01, 16'h0001);
      wait_flag(60, g == 0 || g == 3);
      @(posedge clk_sys_i);
      signal_input_pin_i <= (g == 1);
      auxiliary_gate_pin_i <= (g == 2);
      wait_flag(60, 1'b1);
      wr(16'h6311, 8'h02);
      wr(16'h6312, 8'h03);
      @(posedge clk_sys_i);
      signal_input_pin_i <= 1'b0;
      auxiliary_gate_pin_i <= 1'b0;
    end
    tally_and_finish();
  end
endmodule // testbench
`default_nettype wire
